// file: cfps_pkg.sv
// Package: register map, field layout and encodings of the configuration fuse block
`default_nettype none
package cfps_pkg;

  // ****************************************************************
  // Register map (byte addresses on the bus)
  // ****************************************************************
  localparam logic [31:0] CFPS_ADDR_ROUTE = 32'h0030_0005;
  localparam logic [31:0] CFPS_ADDR_DEBUG = 32'h0030_0006;
  localparam logic [31:0] CFPS_ADDR_MODE = 32'h0030_0004;
  localparam logic [31:0] CFPS_ADDR_PROGRAM = 32'h0000_0000;
  localparam logic [31:0] CFPS_ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] CFPS_ADDR_SCALE = 32'h0000_0003;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CFPS_BIT_DEBUG = 7;
  localparam int CFPS_BIT_LVP = 2;
  localparam int CFPS_BIT_STACK = 0;
  localparam int CFPS_BIT_ROUTE = 0;
  localparam logic [7:0] CFPS_DEBUG_MASK = 8'h85;
  localparam logic [7:0] CFPS_ROUTE_MASK = 8'h01;
  localparam logic [7:0] CFPS_MODE_MASK = 8'h03;

  // Program port: key in the top half, target select and data below
  localparam logic [15:0] CFPS_PROGRAM_KEY = 16'hC0DE;
  localparam logic [1:0] CFPS_TGT_MODE = 2'h0;
  localparam logic [1:0] CFPS_TGT_ROUTE = 2'h1;
  localparam logic [1:0] CFPS_TGT_DEBUG = 2'h2;

  // ****************************************************************
  // Reset values: an unprogrammed fuse reads as one
  // ****************************************************************
  localparam logic [7:0] CFPS_BLANK = 8'hFF;

  // ****************************************************************
  // Processor mode encoding
  // ****************************************************************
  typedef enum logic [1:0]
  {
    CFPS_MODE_EXT_MCU = 2'b00,
    CFPS_MODE_BOOT_MPU = 2'b01,
    CFPS_MODE_MPU = 2'b10,
    CFPS_MODE_SINGLE = 2'b11
  } cfps_mode_type;

  typedef enum logic [1:0]
  {
    CFPS_PIN_C1 = 2'b00,
    CFPS_PIN_E7 = 2'b01,
    CFPS_PIN_B3 = 2'b11
  } cfps_pin_type;

  // Decoded steering handed to the pin logic
  typedef struct packed
  {
    cfps_pin_type capture_pin;
    logic debug_enable;
    logic lvp_enable;
    logic stack_reset_enable;
  } cfps_steer_type;

  // Latched fuse image
  typedef struct packed
  {
    logic [7:0] mode;
    logic [7:0] route;
    logic [7:0] debug;
  } cfps_fuse_type;

endpackage : cfps_pkg
`default_nettype wire

// file: cfps_fuse_cell.sv
// One programmable fuse byte: blank at reset, bits only written by programming
`default_nettype none
module cfps_fuse_cell
  import cfps_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_prog,
  input wire logic [7:0] i_mask,
  input wire logic [7:0] i_data,
  output logic [7:0] o_value
);

  logic [7:0] value_q;
  logic [7:0] value_d;

  // Implemented bits blank to one; unimplemented bits are masked to zero
  assign value_d = i_prog ? (i_data & i_mask) : value_q;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      value_q <= CFPS_BLANK;
    else
      value_q <= value_d;
  end

  assign o_value = value_q & i_mask;

endmodule : cfps_fuse_cell
`default_nettype wire

// file: cfps_route_decode.sv
// Combinational decode of fuse image into pin and debug steering
`default_nettype none
module cfps_route_decode
  import cfps_pkg::*;
(
  input wire cfps_fuse_type i_fuse,
  output cfps_steer_type o_steer
);

  wire route_c1 = i_fuse.route[CFPS_BIT_ROUTE];
  wire single_chip = (cfps_mode_type'(i_fuse.mode[1:0]) == CFPS_MODE_SINGLE);

  assign o_steer.capture_pin = route_c1 ? CFPS_PIN_C1 : // [R01]
    (single_chip ? CFPS_PIN_E7 : CFPS_PIN_B3); // [R02] [R03] [R12]
  assign o_steer.debug_enable = ~i_fuse.debug[CFPS_BIT_DEBUG]; // [R04] [R05]
  assign o_steer.lvp_enable = i_fuse.debug[CFPS_BIT_LVP]; // [R06]
  assign o_steer.stack_reset_enable = i_fuse.debug[CFPS_BIT_STACK]; // [R07]

endmodule : cfps_route_decode
`default_nettype wire

// file: cfps_top.sv
// Top of the configuration fuse block: AHB-Lite slave, fuse bytes and steering outputs
`default_nettype none
// What this block does
// [R01] With the routing bit set the capture/compare unit uses port C pin 1 in every mode.
// [R02] In single-chip mode with the routing bit clear it uses port E pin 7.
// [R03] In the three external memory modes with the routing bit clear it uses port B pin 3.
// [R04] Debug bit at one disables the debugger and leaves port B pins 6 and 7 as plain I/O; the block has a GPIO flag for pin 6 only.
// [R05] Debug bit at zero enables the debugger and gives port B pins 6 and 7 to it.
// [R06] Bit 2 at one permits low-voltage programming entry, at zero forbids it.
// [R07] Bit 0 at one makes a stack full or underflow reset the device, at zero not.
// [R08] Unimplemented bits of the debug byte read as zero.
// [R09] With master clear off the programmer must disable low-voltage entry or hold the select pin low.
// [R10] On small variants the routing byte is absent and must stay all ones.
// [R11] Implemented bits read back, change only by programming and read one when blank.
// [R12] Mode field 11 single-chip, 10 microprocessor, 01 boot-block, 00 extended.
module cfps_top
  import cfps_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  input wire logic I_STACK_FAULT,
  input wire logic I_MASTER_CLEAR_ENABLE,
  input wire logic I_PROGRAMMING_SELECT_PIN,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  output logic [1:0] O_CAPTURE_PIN,
  output logic O_DEBUG_ENABLE,
  output logic O_PORT_B_PIN6_IS_GPIO,
  output logic O_LVP_ENTRY_ENABLE,
  output logic O_STACK_RESET
);

  // ****************************************************************
  // AHB-Lite address phase capture
  // ****************************************************************
  logic wr_pend_q;
  logic [31:0] addr_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  wire addr_take = I_HSEL & I_HREADY & I_HTRANS[1];
  wire wr_take = addr_take & I_HWRITE;

  always_ff @(posedge I_CLOCK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      wr_pend_q <= 1'b0;
      addr_q <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_q <= wr_take;
      addr_q <= addr_take ? I_HADDR : addr_q;
    end
  end

  // ****************************************************************
  // Programming port: a keyed write is the only path that alters fuses
  // ****************************************************************
  wire prog_hit = wr_pend_q & (addr_q == CFPS_ADDR_PROGRAM) & (I_HWDATA[31:16] == CFPS_PROGRAM_KEY);
  wire [1:0] prog_tgt = I_HWDATA[9:8];
  wire [7:0] prog_data = I_HWDATA[7:0];

  // Each fuse byte drives its own field, so the image is a net
  wire cfps_fuse_type fuse;

  cfps_fuse_cell u_mode
  (
    .i_clk(I_CLOCK),
    .i_rst(I_RESET),
    .i_prog(prog_hit & (prog_tgt == CFPS_TGT_MODE)), // [R11]
    .i_mask(CFPS_MODE_MASK),
    .i_data(prog_data),
    .o_value(fuse.mode)
  );

  cfps_fuse_cell u_route
  (
    .i_clk(I_CLOCK),
    .i_rst(I_RESET),
    .i_prog(prog_hit & (prog_tgt == CFPS_TGT_ROUTE)), // [R11]
    .i_mask(CFPS_ROUTE_MASK),
    .i_data(prog_data),
    .o_value(fuse.route)
  );

  cfps_fuse_cell u_debug
  (
    .i_clk(I_CLOCK),
    .i_rst(I_RESET),
    .i_prog(prog_hit & (prog_tgt == CFPS_TGT_DEBUG)), // [R11]
    .i_mask(CFPS_DEBUG_MASK), // [R08]
    .i_data(prog_data),
    .o_value(fuse.debug)
  );

  // ****************************************************************
  // Steering decode
  // ****************************************************************
  cfps_steer_type steer;

  cfps_route_decode u_decode
  (
    .i_fuse(fuse),
    .o_steer(steer)
  );

  // Low-voltage entry needs master clear on or the select pin high; with master clear off the
  // pin alone decides, so a floating select pin must not open the port
  wire lvp_entry = steer.lvp_enable & (I_MASTER_CLEAR_ENABLE | I_PROGRAMMING_SELECT_PIN); // [R06] [R09]

  // ****************************************************************
  // Read mux: plain wires, one registered answer in the data phase
  // ****************************************************************
  wire sel_mode = (I_HADDR == CFPS_ADDR_MODE);
  wire sel_route = (I_HADDR == CFPS_ADDR_ROUTE);
  wire sel_debug = (I_HADDR == CFPS_ADDR_DEBUG);
  wire sel_status = (I_HADDR == CFPS_ADDR_STATUS);
  wire [31:0] status_word = {26'h000_0000, O_STACK_RESET, O_LVP_ENTRY_ENABLE, O_DEBUG_ENABLE, 1'b0, O_CAPTURE_PIN};

  assign rdata_d = ~(addr_take & ~I_HWRITE) ? 32'h0000_0000 :
    sel_mode ? {24'h00_0000, fuse.mode} :
    sel_route ? {24'h00_0000, fuse.route} : // [R11]
    sel_debug ? {24'h00_0000, fuse.debug} : // [R08] [R11]
    sel_status ? status_word :
    32'h0000_0000;

  always_ff @(posedge I_CLOCK or posedge I_RESET)
  begin
    if (I_RESET)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= rdata_d;
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  always_ff @(posedge I_CLOCK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      O_CAPTURE_PIN <= CFPS_PIN_C1;
      O_DEBUG_ENABLE <= 1'b0;
      O_PORT_B_PIN6_IS_GPIO <= 1'b1;
      O_LVP_ENTRY_ENABLE <= 1'b0;
      O_STACK_RESET <= 1'b0;
    end
    else
    begin
      O_CAPTURE_PIN <= steer.capture_pin; // [R01] [R02] [R03]
      O_DEBUG_ENABLE <= steer.debug_enable; // [R05]
      O_PORT_B_PIN6_IS_GPIO <= ~steer.debug_enable; // [R04]
      O_LVP_ENTRY_ENABLE <= lvp_entry; // [R06]
      O_STACK_RESET <= steer.stack_reset_enable & I_STACK_FAULT; // [R07]
    end
  end

  // Zero wait states, always OKAY
  assign O_HRDATA = rdata_q;
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;

endmodule : cfps_top
`default_nettype wire

// file: cfps_top_props.sv
// Port checker for the configuration fuse block
`default_nettype none
module cfps_top_props
  import cfps_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic I_STACK_FAULT,
  input wire logic I_MASTER_CLEAR_ENABLE,
  input wire logic I_PROGRAMMING_SELECT_PIN,
  input wire logic [31:0] O_HRDATA,
  input wire logic O_HREADYOUT,
  input wire logic O_HRESP,
  input wire logic [1:0] O_CAPTURE_PIN,
  input wire logic O_DEBUG_ENABLE,
  input wire logic O_PORT_B_PIN6_IS_GPIO,
  input wire logic O_LVP_ENTRY_ENABLE,
  input wire logic O_STACK_RESET
);
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RESET);
  wire logic take = I_HSEL & I_HTRANS[1];
  wire logic pw = take & I_HWRITE & (I_HADDR == CFPS_ADDR_PROGRAM);
  sequence s_rd(a);
    take && !I_HWRITE && I_HADDR == a;
  endsequence
  chk_bus_okay: assert property (O_HREADYOUT && !O_HRESP) else $error("bus answer not OKAY");
  chk_debug_zero: assert property (s_rd(CFPS_ADDR_DEBUG) |=> (O_HRDATA & ~32'h0000_0085) == 0)
    else $error("unused debug bits set");
  chk_unmapped_zero: assert property (s_rd(32'h0000_0100) |=> O_HRDATA == 0) else $error("unmapped read");
  chk_idle_rdata: assert property (!$past(take && !I_HWRITE) |-> O_HRDATA == 0) else $error("stale read data");
  chk_gpio_debug: assert property (O_PORT_B_PIN6_IS_GPIO != O_DEBUG_ENABLE)
    else $error("debug and gpio disagree");
  chk_stack_gate: assert property (O_STACK_RESET |-> $past(I_STACK_FAULT))
    else $error("stack reset without fault");
  chk_lvp_gate: assert property (O_LVP_ENTRY_ENABLE |-> $past(I_MASTER_CLEAR_ENABLE | I_PROGRAMMING_SELECT_PIN))
    else $error("lvp entry not gated");
  chk_pin_legal: assert property (O_CAPTURE_PIN != 2'b10) else $error("illegal capture pin");
  chk_fuse_hold: assert property ($changed(O_CAPTURE_PIN) || $changed(O_DEBUG_ENABLE) |->
    $past(pw, 2) || $past(pw, 3)) else $error("steering changed without programming");
endmodule : cfps_top_props
`default_nettype wire

// file: cfps_tb_top.sv
// Self-checking testbench of the configuration fuse block
`default_nettype none
module cfps_tb_top
  import cfps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, mce = 1'b1, psel = 1'b0, sf = 1'b1;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic hready, hresp, dbg, gpio, low_voltage_program_enable, stk;
  logic [1:0] cap;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  logic [7:0] dv [4] = '{8'h00, 8'h04, 8'h01, 8'hFF};
  always #10 clk = ~clk;
  cfps_top i_cfps_top (.I_CLOCK(clk), .I_RESET(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready), .I_STACK_FAULT(sf),
    .I_MASTER_CLEAR_ENABLE(mce), .I_PROGRAMMING_SELECT_PIN(psel), .O_HRDATA(hrdata), .O_HREADYOUT(hready),
    .O_HRESP(hresp), .O_CAPTURE_PIN(cap), .O_DEBUG_ENABLE(dbg), .O_PORT_B_PIN6_IS_GPIO(gpio),
    .O_LVP_ENTRY_ENABLE(low_voltage_program_enable), .O_STACK_RESET(stk));
  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdchk
  // Steering lags the fuse update by one edge, so two edges are waited
  task automatic prog(input logic [1:0] t, input logic [7:0] d);
    bus(1'b1, CFPS_ADDR_PROGRAM, {CFPS_PROGRAM_KEY, 6'h00, t, d});
    repeat (2) @(posedge clk);
  endtask : prog
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_blank();
    rdchk(CFPS_ADDR_DEBUG, 32'h0000_0085);
    rdchk(CFPS_ADDR_ROUTE, 32'h0000_0001);
    rdchk(CFPS_ADDR_MODE, 32'h0000_0003);
    chk(32'({cap, dbg, gpio}), 32'h0000_0001);
    $display("test blank done");
  endtask : t_blank
  task automatic t_route();
    for (int m = 0; m < 4; m++)
      for (int r = 0; r < 2; r++)
      begin
        prog(CFPS_TGT_MODE, 8'(m));
        prog(CFPS_TGT_ROUTE, {7'h7F, r[0]});
        rdchk(CFPS_ADDR_ROUTE, 32'(r));
        chk(32'(cap), r ? 32'h0000_0000 : (m == 3 ? 32'h0000_0001 : 32'h0000_0003));
      end
    $display("test route done");
  endtask : t_route
  task automatic t_debug();
    foreach (dv[i])
    begin
      prog(CFPS_TGT_DEBUG, dv[i]);
      rdchk(CFPS_ADDR_DEBUG, 32'(dv[i] & 8'h85));
      chk(32'({dbg, gpio, low_voltage_program_enable, stk}), 32'({~dv[i][7], dv[i][7], dv[i][2], dv[i][0]}));
    end
    mce <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(low_voltage_program_enable), 32'h0000_0000);
    psel <= 1'b1;
    sf <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'({low_voltage_program_enable, stk}), 32'h0000_0002);
    // Status word: stack, lvp, debug, zero, capture pin (route bit set, port C pin 1)
    rdchk(CFPS_ADDR_STATUS, 32'h0000_0010);
    $display("test debug done");
  endtask : t_debug
  task automatic t_bus();
    prog(CFPS_TGT_DEBUG, 8'h00);
    bus(1'b1, CFPS_ADDR_DEBUG, 32'h0000_00FF);
    bus(1'b1, CFPS_ADDR_PROGRAM, {16'h1234, 6'h00, CFPS_TGT_DEBUG, 8'hFF});
    repeat (2) @(posedge clk);
    rdchk(CFPS_ADDR_DEBUG, 32'h0000_0000);
    chk(32'(dbg), 32'h0000_0001);
    rdchk(32'h0000_0100, 32'h0000_0000);
    chk(32'(hresp), 32'h0000_0000);
    prog(CFPS_TGT_ROUTE, 8'hFF);
    rdchk(CFPS_ADDR_ROUTE, 32'h0000_0001);
    $display("test bus done");
  endtask : t_bus
  task automatic finish_test();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      finish_test();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_blank();
    t_route();
    t_debug();
    t_bus();
    finish_test();
  end
endmodule : cfps_tb_top
bind cfps_top cfps_top_props i_cfps_top_props (.I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .I_HSEL(I_HSEL),
  .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_STACK_FAULT(I_STACK_FAULT),
  .I_MASTER_CLEAR_ENABLE(I_MASTER_CLEAR_ENABLE), .I_PROGRAMMING_SELECT_PIN(I_PROGRAMMING_SELECT_PIN),
  .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_CAPTURE_PIN(O_CAPTURE_PIN),
  .O_DEBUG_ENABLE(O_DEBUG_ENABLE), .O_PORT_B_PIN6_IS_GPIO(O_PORT_B_PIN6_IS_GPIO),
  .O_LVP_ENTRY_ENABLE(O_LVP_ENTRY_ENABLE), .O_STACK_RESET(O_STACK_RESET));
`default_nettype wire
